// >>> hw/tcpwm_pkg.sv
package tcpwm_pkg;

    // ------------------------------------------------------------------
    // Field encodings.
    // ------------------------------------------------------------------
    localparam logic [1:0] TCPWM_MODE_UNBUF   = 2'h1;
    localparam logic [1:0] TCPWM_MODE_BUF     = 2'h2;
    localparam logic [1:0] TCPWM_ACT_TOGGLE   = 2'h1;
    localparam logic [1:0] TCPWM_ACT_CLEAR    = 2'h2;
    localparam logic [1:0] TCPWM_ACT_SET      = 2'h3;
    localparam logic [2:0] TCPWM_DIV_MAX_SEL  = 3'h6;
    localparam int         TCPWM_DIV_WIDTH    = 6;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [15:0] TCPWM_LIMIT_RESET  = 16'hffff;
    localparam logic [15:0] TCPWM_MATCH_RESET  = 16'h0000;
    localparam logic        TCPWM_HALT_RESET   = 1'b1;

    // ------------------------------------------------------------------
    // Per-channel control bits.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       event_irq_enable;
        logic [1:0] channel_mode_pair;
        logic [1:0] output_action_select;
        logic       toggle_at_wrap;
        logic       full_duty_select;
    } tcpwm_chan_ctrl_s;

    // Timer-level control bits.
    typedef struct packed {
        logic       counter_halt;
        logic       counter_reset;
        logic       wrap_irq_enable;
        logic [2:0] clock_divider_select;
    } tcpwm_timer_ctrl_s;

endpackage

// >>> hw/tcpwm_top.sv
// Notes on behaviour
// RULE_01: Unbuffered mode compares counter directly against the channel value as written.
// RULE_02: A new value already passed by the counter yields no compare that period.
// RULE_03: Software shortening a width writes it in the compare interrupt handler.
// RULE_04: Software lengthening a width writes it in the overflow interrupt handler.
// RULE_05: Compare flag marks end of pulse; wrap flag marks end of period.
// RULE_06: Link bit on channel 0 joins both channels; output only on pin 0.
// RULE_07: Linked: channel 0 first, then last-written pair takes over at each overflow.
// RULE_08: Linked: channel 1 control ignored, its pin released to general I/O; channel 1 full-duty with toggle-at-wrap still forces its pin level high.
// RULE_09: Software writes only the inactive pair when buffered.
// RULE_10: Toggle-at-wrap toggles the pin whenever counter reaches the limit.
// RULE_11: Width is overflow to compare; compare drives the pulse complement.
// RULE_12: Period is limit plus one prescaled timer clocks.
// RULE_13: Pulse width equals the compare value in timer clocks.
// RULE_14: Software must not select toggle-on-compare for PWM.
// RULE_15: Software halts, resets, writes limit, width, mode, then releases halt.
// RULE_16: Mode pair 0:1 is unbuffered, 1:0 is buffered linked pair.
// RULE_17: Action pair 1:0 clears the output on compare, 1:1 sets it.
// RULE_18: Without toggle-at-wrap the pin is not toggled, giving 0% duty.
// RULE_19: Full-duty with toggle-at-wrap holds the output at 100%.
// RULE_20: At the limit the wrap flag sets and the counter restarts from zero.
// RULE_21: Divider select 0..6 divides bus clock by 1..64; code 7 unavailable.
// RULE_22: Compare sets the channel flag; enabled flags request an interrupt.
// RULE_23: Match occurs in the timer tick where counter equals active compare value.
`timescale 1ns/1ns
`default_nettype none
module tcpwm_top
    import tcpwm_pkg::*;
(
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic                          clk_en,
    input  wire tcpwm_pkg::tcpwm_timer_ctrl_s  timer_ctrl,
    input  wire tcpwm_pkg::tcpwm_chan_ctrl_s   first_channel_ctrl,
    input  wire tcpwm_pkg::tcpwm_chan_ctrl_s   second_channel_ctrl,
    input  wire logic                          link_pair_select,
    input  wire logic [15:0]                   period_limit_value,
    input  wire logic [15:0]                   first_match_value,
    input  wire logic                          first_match_write,
    input  wire logic [15:0]                   second_match_value,
    input  wire logic                          second_match_write,
    input  wire logic                          wrap_flag_clear,
    input  wire logic [1:0]                    channel_event_clear,
    output logic [15:0]                        counter_value,
    output logic                               wrap_flag,
    output logic [1:0]                         channel_event_flag,
    output logic                               timer_irq,
    output logic                               first_channel_pin,
    output logic                               first_channel_oe,
    output logic                               second_channel_pin,
    output logic                               second_channel_oe
);
    import tcpwm_pkg::*;

    // ------------------------------------------------------------------
    // Shared helpers.
    // ------------------------------------------------------------------
    function automatic logic is_compare_mode(input logic [1:0] mode);
        return (mode == TCPWM_MODE_UNBUF) || (mode == TCPWM_MODE_BUF);
    endfunction

    // Returns the pin level after a compare action.
    function automatic logic compare_action(input logic [1:0] act, input logic pin);
        unique case (act)
            TCPWM_ACT_TOGGLE: return ~pin;
            TCPWM_ACT_CLEAR:  return 1'b0;
            TCPWM_ACT_SET:    return 1'b1;
            default:          return pin;
        endcase
    endfunction

    // Returns high on bus clocks on which the selected divider output advances the counter.
    function automatic logic divider_tick(input logic [TCPWM_DIV_WIDTH-1:0] presc,
                                          input logic [2:0]                 sel);
        logic [TCPWM_DIV_WIDTH-1:0] mask;
        mask = (TCPWM_DIV_WIDTH'(1) << sel) - TCPWM_DIV_WIDTH'(1);
        return (sel <= TCPWM_DIV_MAX_SEL) && ((presc & mask) == '0);
    endfunction

    // ------------------------------------------------------------------
    // Registered state.
    // ------------------------------------------------------------------
    logic [TCPWM_DIV_WIDTH-1:0] presc_reg, presc_next;
    logic [15:0]                count_reg, count_next;
    logic [15:0]                match0_reg, match0_next;
    logic [15:0]                match1_reg, match1_next;
    logic                       active_sel_reg, active_sel_next;
    logic                       last_written_reg, last_written_next;
    logic                       wrap_reg, wrap_next;
    logic [1:0]                 chev_reg, chev_next;
    logic [1:0]                 pin_reg, pin_next;

    // ------------------------------------------------------------------
    // Combinational next state.
    // ------------------------------------------------------------------
    logic             tick;
    logic             at_limit;
    logic [15:0]      cnt_step;
    logic             linked;
    logic [1:0]       match_hit;
    logic [15:0]      active_match;
    tcpwm_chan_ctrl_s ch_ctrl [2];

    always_comb begin
        ch_ctrl[0]  = first_channel_ctrl;
        ch_ctrl[1]  = second_channel_ctrl;
        // Linking needs the buffered mode code as well, so a stray link bit alone does nothing.
        linked      = link_pair_select // see RULE_06, RULE_16
                      && (first_channel_ctrl.channel_mode_pair == TCPWM_MODE_BUF);
        // Halt and a held counter reset stop the count, so no event fires meanwhile.
        tick        = divider_tick(presc_reg, timer_ctrl.clock_divider_select)
                      && !timer_ctrl.counter_halt && !timer_ctrl.counter_reset; // see RULE_21
        at_limit    = (count_reg == period_limit_value);
        cnt_step    = at_limit ? 16'h0000 : count_reg + 16'h0001;
        active_match = (linked && active_sel_reg) ? match1_reg : match0_reg; // see RULE_07
        // Matching the value the counter steps to lets the pin change as the counter shows the
        // compare value, so the pulse lasts exactly the compare value in timer clocks.
        match_hit[0] = tick && is_compare_mode(ch_ctrl[0].channel_mode_pair)
                       && (cnt_step == active_match); // see RULE_01, RULE_02, RULE_13, RULE_23
        match_hit[1] = tick && !linked && is_compare_mode(ch_ctrl[1].channel_mode_pair)
                       && (cnt_step == match1_reg); // see RULE_08

        presc_next        = presc_reg + TCPWM_DIV_WIDTH'(1);
        count_next        = count_reg;
        match0_next       = first_match_write ? first_match_value : match0_reg;
        match1_next       = second_match_write ? second_match_value : match1_reg;
        active_sel_next   = active_sel_reg;
        last_written_next = last_written_reg;
        // The pair written last, not the active one, decides the next hand-over.
        if (first_match_write) begin
            last_written_next = 1'b0;
        end
        if (second_match_write) begin
            last_written_next = 1'b1;
        end
        pin_next = pin_reg;

        if (tick) begin
            count_next = cnt_step; // see RULE_12, RULE_20
        end
        // An unavailable divider code freezes the prescaler as well as the counter.
        if (timer_ctrl.clock_divider_select > TCPWM_DIV_MAX_SEL) begin
            presc_next = presc_reg;
        end
        if (timer_ctrl.counter_halt) begin
            presc_next = presc_reg;
        end
        if (timer_ctrl.counter_reset) begin
            presc_next = '0;
            count_next = 16'h0000;
        end

        // The hand-over waits for an overflow, so a running pulse is never cut short.
        if (!linked) begin
            active_sel_next = 1'b0;
        end else if (tick && at_limit) begin
            active_sel_next = last_written_reg; // see RULE_07
        end

        for (int c = 0; c < 2; c++) begin
            if (match_hit[c]) begin
                pin_next[c] = compare_action(ch_ctrl[c].output_action_select,
                                             pin_next[c]); // see RULE_11, RULE_13, RULE_17
            end
            // Toggle-at-wrap comes after the compare action and wins on a shared tick.
            if (tick && at_limit && ch_ctrl[c].toggle_at_wrap
                    && !(c == 1 && linked)) begin
                pin_next[c] = ~pin_reg[c]; // see RULE_10, RULE_18
            end
            // Full duty with toggle-at-wrap overrides both actions on every cycle, halted or not.
            if (ch_ctrl[c].full_duty_select && ch_ctrl[c].toggle_at_wrap) begin
                pin_next[c] = 1'b1; // see RULE_19
            end
        end

        // Set wins over a clear arriving in the same cycle.
        wrap_next = (wrap_reg && !wrap_flag_clear) || (tick && at_limit); // see RULE_05, RULE_20
        chev_next = (chev_reg & ~channel_event_clear) | match_hit; // see RULE_05, RULE_22
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            presc_reg        <= '0;
            count_reg        <= 16'h0000;
            match0_reg       <= TCPWM_MATCH_RESET;
            match1_reg       <= TCPWM_MATCH_RESET;
            active_sel_reg   <= 1'b0;
            last_written_reg <= 1'b0;
            wrap_reg         <= 1'b0;
            chev_reg         <= 2'h0;
            pin_reg          <= 2'h0;
        end else if (clk_en) begin
            presc_reg        <= presc_next;
            count_reg        <= count_next;
            match0_reg       <= match0_next;
            match1_reg       <= match1_next;
            active_sel_reg   <= active_sel_next;
            last_written_reg <= last_written_next;
            wrap_reg         <= wrap_next;
            chev_reg         <= chev_next;
            pin_reg          <= pin_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    always_comb begin
        counter_value      = count_reg;
        wrap_flag          = wrap_reg;
        channel_event_flag = chev_reg;
        timer_irq          = (wrap_reg && timer_ctrl.wrap_irq_enable)
                             || (chev_reg[0] && first_channel_ctrl.event_irq_enable)
                             || (chev_reg[1] && !linked
                                 && second_channel_ctrl.event_irq_enable); // see RULE_22, RULE_08
        first_channel_pin  = pin_reg[0];
        first_channel_oe   = is_compare_mode(first_channel_ctrl.channel_mode_pair);
        second_channel_pin = pin_reg[1];
        // A released second pin is left to the port logic as general-purpose I/O.
        second_channel_oe  = !linked
                             && is_compare_mode(second_channel_ctrl.channel_mode_pair); // see RULE_08
    end

endmodule
`default_nettype wire

// >>> test/tcpwm_props.sv
`timescale 1ns/1ns
`default_nettype none
module tcpwm_props
    import tcpwm_pkg::*;
(
    input wire logic                         core_clk,
    input wire logic                         rst,
    input wire logic                         clk_en,
    input wire tcpwm_pkg::tcpwm_timer_ctrl_s timer_ctrl,
    input wire tcpwm_pkg::tcpwm_chan_ctrl_s  first_channel_ctrl,
    input wire logic                         link_pair_select,
    input wire logic [15:0]                  period_limit_value,
    input wire logic [15:0]                  first_match_value,
    input wire logic                         first_match_write,
    input wire logic [15:0]                  counter_value,
    input wire logic                         wrap_flag,
    input wire logic [1:0]                   channel_event_flag,
    input wire logic                         first_channel_pin,
    input wire logic                         second_channel_oe
);
    logic [15:0] m0_reg;
    logic        tk;
    logic        cfg;
    logic        hit;
    logic        wrp;
    logic [15:0] nxt;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            m0_reg <= 16'h0000;
        end else if (clk_en && first_match_write) begin
            m0_reg <= first_match_value;
        end
    end
    assign tk  = clk_en && !timer_ctrl.counter_halt && !timer_ctrl.counter_reset
                 && timer_ctrl.clock_divider_select == 3'h0;
    assign cfg = !link_pair_select && first_channel_ctrl.channel_mode_pair == TCPWM_MODE_UNBUF
                 && !first_channel_ctrl.full_duty_select;
    assign hit = tk && cfg && nxt == m0_reg;
    assign wrp = tk && counter_value == period_limit_value;
    assign nxt = wrp ? 16'h0000 : counter_value + 16'h0001;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_wrap_restart: assert property (wrp |=> counter_value == 16'h0000 && wrap_flag)
        else $error("no restart at limit");
    a_count_step: assert property (tk && !wrp |=> counter_value == $past(counter_value) + 16'h0001)
        else $error("count step wrong");
    a_match_flag: assert property (hit |=> channel_event_flag[0])
        else $error("match flag missing");
    a_match_clear: assert property (hit && !wrp && first_channel_ctrl.output_action_select == TCPWM_ACT_CLEAR |=> !first_channel_pin)
        else $error("clear on match failed");
    a_match_set: assert property (hit && !wrp && first_channel_ctrl.output_action_select == TCPWM_ACT_SET |=> first_channel_pin)
        else $error("set on match failed");
    a_wrap_toggle: assert property (wrp && cfg && first_channel_ctrl.toggle_at_wrap && !hit |=> first_channel_pin != $past(first_channel_pin))
        else $error("no toggle at wrap");
    a_wrap_hold: assert property (wrp && cfg && !first_channel_ctrl.toggle_at_wrap && !hit |=> $stable(first_channel_pin))
        else $error("pin moved at wrap");
    a_full_duty: assert property (clk_en && !link_pair_select && first_channel_ctrl.full_duty_select && first_channel_ctrl.toggle_at_wrap && first_channel_ctrl.channel_mode_pair == TCPWM_MODE_UNBUF |=> first_channel_pin)
        else $error("full duty not held");
    a_link_release: assert property (link_pair_select && first_channel_ctrl.channel_mode_pair == TCPWM_MODE_BUF |-> !second_channel_oe)
        else $error("second pin not released");
    c_wrap: cover property (wrp && cfg);
    c_hit: cover property (hit && !wrp);
    c_link: cover property (link_pair_select && tk);
endmodule
bind tcpwm_top tcpwm_props u_props (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
    .timer_ctrl(timer_ctrl), .first_channel_ctrl(first_channel_ctrl),
    .link_pair_select(link_pair_select), .period_limit_value(period_limit_value),
    .first_match_value(first_match_value), .first_match_write(first_match_write),
    .counter_value(counter_value), .wrap_flag(wrap_flag), .channel_event_flag(channel_event_flag),
    .first_channel_pin(first_channel_pin), .second_channel_oe(second_channel_oe));
`default_nettype wire

// >>> test/tcpwm_load_model.sv
`timescale 1ns/1ns
`default_nettype none
module tcpwm_load_model (
    input wire logic core_clk,
    input wire logic pin,
    input wire logic oe,
    input wire logic meas,
    output var int   high_cnt,
    output var int   rise_cnt
);
    logic lvl;
    logic last;
    // The load has a pull-down, so a released pin reads low.
    assign lvl = oe ? pin : 1'b0;
    always @(posedge core_clk) begin
        last <= lvl;
        high_cnt <= meas ? high_cnt + int'(lvl) : 0;
        rise_cnt <= meas ? rise_cnt + int'(lvl && !last) : 0;
    end
endmodule
`default_nettype wire

// >>> test/timer_compare_pwm_channels_bench.sv
`timescale 1ns/1ns
`default_nettype none
module timer_compare_pwm_channels_bench;
    import tcpwm_pkg::*;
    typedef struct packed {
        logic [2:0] dv; logic [15:0] lim; logic [15:0] m; logic [1:0] act;
        logic tov; logic fd; logic [15:0] hi; logic [15:0] ri;
    } tcpwm_row_s;
    // High cycles and rising edges over four periods; width is overflow to match.
    tcpwm_row_s rows [7] = '{
        '{3'h0, 16'h0009, 16'h0002, TCPWM_ACT_CLEAR, 1'b1, 1'b0, 16'h0008, 16'h0004},
        '{3'h0, 16'h0009, 16'h0002, TCPWM_ACT_SET, 1'b1, 1'b0, 16'h0020, 16'h0004},
        '{3'h0, 16'h0009, 16'h0002, TCPWM_ACT_CLEAR, 1'b0, 1'b0, 16'h0000, 16'h0000},
        '{3'h0, 16'h0009, 16'h0002, TCPWM_ACT_CLEAR, 1'b1, 1'b1, 16'h0028, 16'h0000},
        '{3'h1, 16'h0003, 16'h0001, TCPWM_ACT_CLEAR, 1'b1, 1'b0, 16'h0008, 16'h0004},
        '{3'h6, 16'h0001, 16'h0001, TCPWM_ACT_CLEAR, 1'b1, 1'b0, 16'h0100, 16'h0004},
        '{3'h0, 16'h00ff, 16'h0080, TCPWM_ACT_CLEAR, 1'b1, 1'b0, 16'h0200, 16'h0004}};
    logic core_clk, rst, ce, lnk, w0, w1, wclr, meas, wf, irq, p0, oe0, p1, oe1;
    logic [15:0] lim, m0, m1, cnt, snap;
    logic [1:0] eclr, ef;
    tcpwm_timer_ctrl_s tc;
    tcpwm_chan_ctrl_s c0, c1;
    int high_cnt, rise_cnt, errors, n_tests;
    tcpwm_top u_dut (.core_clk(core_clk), .rst(rst), .clk_en(ce), .timer_ctrl(tc),
        .first_channel_ctrl(c0), .second_channel_ctrl(c1), .link_pair_select(lnk),
        .period_limit_value(lim), .first_match_value(m0), .first_match_write(w0),
        .second_match_value(m1), .second_match_write(w1), .wrap_flag_clear(wclr),
        .channel_event_clear(eclr), .counter_value(cnt), .wrap_flag(wf), .channel_event_flag(ef),
        .timer_irq(irq), .first_channel_pin(p0), .first_channel_oe(oe0),
        .second_channel_pin(p1), .second_channel_oe(oe1));
    tcpwm_load_model u_load (.core_clk(core_clk), .pin(p0), .oe(oe0), .meas(meas),
        .high_cnt(high_cnt), .rise_cnt(rise_cnt));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %0h expected %0h", $time, s, got, exp);
        end
    endtask
    task automatic measure(input int w, input logic [15:0] hi, input logic [15:0] ri);
        repeat (w / 2) @(negedge core_clk);
        meas = 1'b1;
        repeat (w) @(negedge core_clk);
        meas = 1'b0;
        chk(high_cnt[15:0], hi, "high time");
        chk(rise_cnt[15:0], ri, "period count");
        $display("test done at %0t", $time);
    endtask
    task automatic run(input tcpwm_row_s r, input logic [1:0] md);
        tc = '{1'b1, 1'b1, 1'b0, r.dv};
        @(negedge core_clk);
        lim = r.lim;
        m0 = r.m;
        w0 = 1'b1;
        c0 = '{1'b1, md, r.act, r.tov, r.fd};
        @(negedge core_clk);
        w0 = 1'b0;
        tc.counter_reset = 1'b0;
        @(negedge core_clk);
        tc.counter_halt = 1'b0;
        measure((int'(r.lim) + 1) * (1 << r.dv) * 4, r.hi, r.ri);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    initial begin
        ce = 1'b1;
        {rst, lnk, w0, w1, wclr, meas, eclr, m0, m1} = {1'b1, 39'h0};
        {tc, c0, c1, lim} = {TCPWM_HALT_RESET, 19'h0, TCPWM_LIMIT_RESET};
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        chk(cnt, 16'h0000, "reset count");
        chk({13'h0, wf, ef}, 16'h0000, "reset flags");
        foreach (rows[i]) run(rows[i], TCPWM_MODE_UNBUF);
        tc.counter_halt = 1'b1;
        @(negedge core_clk);
        chk({13'h0, wf, ef[0], irq}, 16'h0007, "flags set");
        eclr = 2'h3;
        wclr = 1'b1;
        @(negedge core_clk);
        {eclr, wclr} = 3'h0;
        @(negedge core_clk);
        chk({13'h0, wf, ef[0], irq}, 16'h0000, "flags cleared");
        $display("flag test done at %0t", $time);
        lnk = 1'b1;
        c1 = '{1'b0, TCPWM_MODE_UNBUF, TCPWM_ACT_SET, 1'b1, 1'b1};
        run('{3'h0, 16'h0009, 16'h0001, TCPWM_ACT_CLEAR, 1'b1, 1'b0, 16'h0004, 16'h0004},
            TCPWM_MODE_BUF);
        chk({15'h0, oe1}, 16'h0000, "second pin released");
        m1 = 16'h0005;
        w1 = 1'b1;
        @(negedge core_clk);
        w1 = 1'b0;
        measure(40, 16'h0014, 16'h0004);
        ce = 1'b0;
        snap = cnt;
        repeat (3) @(negedge core_clk);
        chk(cnt, snap, "frozen count");
        ce = 1'b1;
        lnk = 1'b0;
        c0.channel_mode_pair = TCPWM_MODE_UNBUF;
        @(negedge core_clk);
        chk({14'h0, oe1, p1}, 16'h0003, "second pin own");
        $display("freeze and unlink test done at %0t", $time);
        {wclr, eclr} = 3'h7;
        @(negedge core_clk);
        {wclr, eclr} = 3'h0;
        while (!wf) @(negedge core_clk);
        m0 = 16'h0006;
        w0 = 1'b1;
        @(negedge core_clk);
        w0 = 1'b0;
        measure(40, 16'h0018, 16'h0004);
        eclr = 2'h1;
        @(negedge core_clk);
        eclr = 2'h0;
        while (!ef[0]) @(negedge core_clk);
        m0 = 16'h0003;
        w0 = 1'b1;
        @(negedge core_clk);
        w0 = 1'b0;
        measure(40, 16'h000c, 16'h0004);
        rst = 1'b1;
        @(negedge core_clk);
        rst = 1'b0;
        chk(cnt, 16'h0000, "mid-run reset");
        $display("reset test done at %0t", $time);
        tally_and_finish();
    end
endmodule
`default_nettype wire
